// [cse_exec.sv]
// executor for one group of instructions: working register, zero flag, program counter
`timescale 1ns/1ps
// Summary of operation
// - increment file into working or file register
// - skip on zero result discards fetched word
// - skipping takes two cycles, flags untouched
// - branch loads nine immediate bits into counter
// - page bits fill counter bits ten, nine
// - branch takes two cycles, second refills
// - OR literal into working register, zero updated
// - OR file, destination selectable, zero updated
// - working register to file, flags untouched
// - move file to working or itself
// - move file always updates zero flag
// - load literal, flags untouched
module cse_exec #(
	parameter int PC_W   = cse_pkg::PC_WIDTH,
	parameter int DATA_W = cse_pkg::DATA_WIDTH
) (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst,
	// fetch path
	input  wire logic                            instr_valid,
	input  wire logic [cse_pkg::INSTR_WIDTH-1:0] instr,
	// data file and status page bits
	input  wire logic [DATA_W-1:0]               file_rdata,
	input  wire logic [cse_pkg::PAGE_WIDTH-1:0]  page_bits,
	// file write port
	output logic                                 file_we_r,
	output logic [cse_pkg::FADDR_WIDTH-1:0]      file_waddr_r,
	output logic [DATA_W-1:0]                    file_wdata_r,
	// core state
	output logic [DATA_W-1:0]                    acc_r,
	output logic                                 zero_r,
	output logic [PC_W-1:0]                      pc_r,
	output logic                                 discard_r
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks: the page and target fields fix the counter width
	if (PC_W != cse_pkg::PC_WIDTH)
		$error("cse_exec: PC_W must equal the page plus target width");
	if (DATA_W != cse_pkg::DATA_WIDTH)
		$error("cse_exec: DATA_W must equal the 8-bit data path");

	////////////////////////////////////////////////////////////////////////////////
	// decode and datapath
	cse_pkg::cse_op_t                   op;
	logic [cse_pkg::FADDR_WIDTH-1:0]    faddr;
	logic                               dest;
	logic [DATA_W-1:0]                  lit;
	logic [cse_pkg::TGT_WIDTH-1:0]      target;
	logic [DATA_W-1:0]                  result;
	logic                               res_zero;

	cse_decode u_decode (
		.instr  (instr),
		.op     (op),
		.faddr  (faddr),
		.dest   (dest),
		.lit    (lit),
		.target (target)
	);

	cse_alu u_alu (
		.op     (op),
		.acc    (acc_r),
		.fdata  (file_rdata),
		.lit    (lit),
		.result (result),
		.zero   (res_zero)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state
	cse_pkg::cse_state_t                state_r;
	cse_pkg::cse_state_t                state_nxt;
	logic [DATA_W-1:0]                  acc_nxt;
	logic                               zero_nxt;
	logic [PC_W-1:0]                    pc_nxt;
	logic                               file_we_nxt;
	logic [cse_pkg::FADDR_WIDTH-1:0]    file_waddr_nxt;
	logic [DATA_W-1:0]                  file_wdata_nxt;
	logic                               discard_nxt;
	logic                               exec_go;

	assign exec_go = instr_valid && (state_r == cse_pkg::CSE_ST_EXEC);

	always_comb
	begin
		state_nxt      = state_r;
		acc_nxt        = acc_r;
		zero_nxt       = zero_r;
		pc_nxt         = pc_r;
		file_we_nxt    = 1'b0;
		file_waddr_nxt = file_waddr_r;
		file_wdata_nxt = file_wdata_r;
		if (instr_valid)
		begin
			pc_nxt    = pc_r + cse_pkg::PC_STEP;
			state_nxt = cse_pkg::CSE_ST_EXEC;
			// a discarded word executes as no_operation
			if (state_r == cse_pkg::CSE_ST_EXEC)
			begin
				unique case (op)
					cse_pkg::CSE_OP_INC, cse_pkg::CSE_OP_ORF, cse_pkg::CSE_OP_MOVE,
					cse_pkg::CSE_OP_INCSZ:
					begin
						if (dest)
						begin
							file_we_nxt    = 1'b1;
							file_waddr_nxt = faddr;
							file_wdata_nxt = result;
						end
						else
							acc_nxt = result;
						if (op != cse_pkg::CSE_OP_INCSZ)
							zero_nxt = res_zero;
						else if (res_zero)
							state_nxt = cse_pkg::CSE_ST_FLUSH;
					end
					cse_pkg::CSE_OP_BRA:
					begin
						pc_nxt    = {page_bits, target};
						state_nxt = cse_pkg::CSE_ST_FLUSH;
					end
					cse_pkg::CSE_OP_ORLIT:
					begin
						acc_nxt  = result;
						zero_nxt = res_zero;
					end
					cse_pkg::CSE_OP_STORE:
					begin
						file_we_nxt    = 1'b1;
						file_waddr_nxt = faddr;
						file_wdata_nxt = acc_r;
					end
					cse_pkg::CSE_OP_LDLIT:
						acc_nxt = result;
					cse_pkg::CSE_OP_NONE:
						acc_nxt = acc_r;
				endcase
			end
		end
		discard_nxt = (state_nxt == cse_pkg::CSE_ST_FLUSH);
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r      <= cse_pkg::CSE_ST_EXEC;
			acc_r        <= cse_pkg::ACC_RST;
			zero_r       <= cse_pkg::ZERO_RST;
			pc_r         <= cse_pkg::PC_RST;
			file_we_r    <= 1'b0;
			file_waddr_r <= cse_pkg::FADDR_RST;
			file_wdata_r <= cse_pkg::ACC_RST;
			discard_r    <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			acc_r        <= acc_nxt;
			zero_r       <= zero_nxt;
			pc_r         <= pc_nxt;
			file_we_r    <= file_we_nxt;
			file_waddr_r <= file_waddr_nxt;
			file_wdata_r <= file_wdata_nxt;
			discard_r    <= discard_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_inc_to_acc: assert property (
		exec_go && op == cse_pkg::CSE_OP_INC && !dest
		|=> acc_r == DATA_W'($past(file_rdata) + cse_pkg::ONE) && !file_we_r
			&& zero_r == (acc_r == cse_pkg::ZERO_VAL))
		else $error("increment into working register wrong");

	chk_inc_to_file: assert property (
		exec_go && op == cse_pkg::CSE_OP_INC && dest
		|=> file_we_r && file_waddr_r == $past(faddr) && $stable(acc_r)
			&& file_wdata_r == DATA_W'($past(file_rdata) + cse_pkg::ONE))
		else $error("increment into file register wrong");

	chk_skip_discard: assert property (
		exec_go && op == cse_pkg::CSE_OP_INCSZ && res_zero
		|=> discard_r && state_r == cse_pkg::CSE_ST_FLUSH)
		else $error("skip did not discard fetched word");

	chk_skip_dest: assert property (
		exec_go && op == cse_pkg::CSE_OP_INCSZ
		|=> file_we_r == $past(dest)
			&& ($past(dest) ? file_wdata_r : acc_r) == DATA_W'($past(file_rdata) + cse_pkg::ONE))
		else $error("skip increment result wrong");

	chk_skip_keep: assert property (
		exec_go && op == cse_pkg::CSE_OP_INCSZ && !res_zero
		|=> !discard_r)
		else $error("skip taken on nonzero result");

	// the wasted word must leave no trace but the counter step
	chk_discard_quiet: assert property (
		discard_r && instr_valid
		|=> !discard_r && $stable(acc_r) && $stable(zero_r) && !file_we_r
			&& pc_r == PC_W'($past(pc_r) + cse_pkg::PC_STEP))
		else $error("discarded word had an effect");

	chk_skip_flags: assert property (
		exec_go && op == cse_pkg::CSE_OP_INCSZ
		|=> $stable(zero_r) ##1 (!discard_r || !$past(instr_valid)))
		else $error("skip changed flags or overran two cycles");

	chk_branch_target: assert property (
		exec_go && op == cse_pkg::CSE_OP_BRA
		|=> pc_r[cse_pkg::TGT_WIDTH-1:0] == $past(target) && $stable(zero_r) && $stable(acc_r))
		else $error("branch target bits wrong");

	chk_branch_page: assert property (
		exec_go && op == cse_pkg::CSE_OP_BRA
		|=> pc_r[PC_W-1:cse_pkg::TGT_WIDTH] == $past(page_bits))
		else $error("branch page bits wrong");

	chk_branch_refill: assert property (
		exec_go && op == cse_pkg::CSE_OP_BRA
		|=> discard_r ##1 (!$past(instr_valid) || (!discard_r && !file_we_r)))
		else $error("branch refill cycle wrong");

	chk_branch_resume: assert property (
		exec_go && op == cse_pkg::CSE_OP_BRA ##1 instr_valid
		|=> !discard_r && pc_r == PC_W'($past(pc_r) + cse_pkg::PC_STEP))
		else $error("branch did not resume after refill");

	chk_or_literal: assert property (
		exec_go && op == cse_pkg::CSE_OP_ORLIT
		|=> acc_r == ($past(acc_r) | $past(lit)) && zero_r == (acc_r == cse_pkg::ZERO_VAL))
		else $error("or literal result wrong");

	chk_or_file: assert property (
		exec_go && op == cse_pkg::CSE_OP_ORF && dest
		|=> file_we_r && file_wdata_r == ($past(acc_r) | $past(file_rdata)) && $stable(acc_r)
			&& zero_r == (file_wdata_r == cse_pkg::ZERO_VAL))
		else $error("or with file result wrong");

	chk_or_to_acc: assert property (
		exec_go && op == cse_pkg::CSE_OP_ORF && !dest
		|=> acc_r == ($past(acc_r) | $past(file_rdata)) && !file_we_r
			&& zero_r == (acc_r == cse_pkg::ZERO_VAL))
		else $error("or with file into working register wrong");

	chk_store_acc: assert property (
		exec_go && op == cse_pkg::CSE_OP_STORE
		|=> file_we_r && file_wdata_r == $past(acc_r) && file_waddr_r == $past(faddr) && $stable(zero_r))
		else $error("store working register wrong");

	chk_move_file: assert property (
		exec_go && op == cse_pkg::CSE_OP_MOVE && !dest
		|=> acc_r == $past(file_rdata) && !file_we_r)
		else $error("move file to working register wrong");

	chk_move_zero: assert property (
		exec_go && op == cse_pkg::CSE_OP_MOVE && dest
		|=> file_we_r && file_waddr_r == $past(faddr) && zero_r == ($past(file_rdata) == cse_pkg::ZERO_VAL))
		else $error("move file zero flag wrong");

	chk_load_literal: assert property (
		exec_go && op == cse_pkg::CSE_OP_LDLIT
		|=> acc_r == $past(lit) && $stable(zero_r))
		else $error("load literal wrong");

	chk_literal_quiet: assert property (
		exec_go && (op == cse_pkg::CSE_OP_LDLIT || op == cse_pkg::CSE_OP_ORLIT)
		|=> !file_we_r && !discard_r)
		else $error("literal operation touched the file");

	chk_empty_word: assert property (
		exec_go && op == cse_pkg::CSE_OP_NONE
		|=> $stable(acc_r) && $stable(zero_r) && !file_we_r && !discard_r
			&& pc_r == PC_W'($past(pc_r) + cse_pkg::PC_STEP))
		else $error("no_operation changed state");

	chk_idle_hold: assert property (
		!instr_valid
		|=> $stable(pc_r) && $stable(acc_r) && $stable(zero_r) && !file_we_r)
		else $error("idle cycle changed state");

	chk_zero_source: assert property (
		$changed(zero_r) |-> $past(exec_go) && ($past(op) == cse_pkg::CSE_OP_INC
			|| $past(op) == cse_pkg::CSE_OP_ORLIT || $past(op) == cse_pkg::CSE_OP_ORF
			|| $past(op) == cse_pkg::CSE_OP_MOVE))
		else $error("zero flag changed by wrong instruction");

	cov_skip_taken: cover property (exec_go && op == cse_pkg::CSE_OP_INCSZ && res_zero ##1 discard_r);
	cov_branch: cover property (exec_go && op == cse_pkg::CSE_OP_BRA ##1 discard_r && instr_valid ##1 !discard_r);
	cov_move_test: cover property (exec_go && op == cse_pkg::CSE_OP_MOVE && dest && res_zero);
	cov_discard_wait: cover property (discard_r && !instr_valid ##1 discard_r);
	cov_or_file_acc: cover property (exec_go && op == cse_pkg::CSE_OP_ORF && !dest);

endmodule // cse_exec

// [cse_pkg.sv]
// shared encodings, widths and reset values for the instruction subset executor
package cse_pkg;

	localparam int DATA_WIDTH  = 8;
	localparam int PC_WIDTH    = 11;
	localparam int INSTR_WIDTH = 12;
	localparam int FADDR_WIDTH = 5;
	localparam int TGT_WIDTH   = 9;
	localparam int PAGE_WIDTH  = 2;

	// instruction field positions
	localparam int FADDR_LSB = 0;
	localparam int DEST_BIT  = 5;
	localparam int LIT_LSB   = 0;
	localparam int TGT_LSB   = 0;

	// reset values and arithmetic constants
	localparam logic [DATA_WIDTH-1:0]  ACC_RST  = 8'h00;
	localparam logic [PC_WIDTH-1:0]    PC_RST   = 11'h000;
	localparam logic                   ZERO_RST = 1'b0;
	localparam logic [DATA_WIDTH-1:0]  ONE      = 8'h01;
	localparam logic [DATA_WIDTH-1:0]  ZERO_VAL = 8'h00;
	localparam logic [PC_WIDTH-1:0]    PC_STEP  = 11'h001;
	localparam logic [FADDR_WIDTH-1:0] FADDR_RST = 5'h00;

	// opcode match masks and values
	localparam logic [INSTR_WIDTH-1:0] M_INC_FILE  = 12'hfc0;
	localparam logic [INSTR_WIDTH-1:0] V_INC_FILE  = 12'h280;
	localparam logic [INSTR_WIDTH-1:0] M_INC_SKIP  = 12'hfc0;
	localparam logic [INSTR_WIDTH-1:0] V_INC_SKIP  = 12'h3c0;
	localparam logic [INSTR_WIDTH-1:0] M_BRANCH    = 12'he00;
	localparam logic [INSTR_WIDTH-1:0] V_BRANCH    = 12'ha00;
	localparam logic [INSTR_WIDTH-1:0] M_ORLIT     = 12'hf00;
	localparam logic [INSTR_WIDTH-1:0] V_ORLIT     = 12'hd00;
	localparam logic [INSTR_WIDTH-1:0] M_ORFILE    = 12'hfc0;
	localparam logic [INSTR_WIDTH-1:0] V_ORFILE    = 12'h100;
	localparam logic [INSTR_WIDTH-1:0] M_STORE_ACC = 12'hfe0;
	localparam logic [INSTR_WIDTH-1:0] V_STORE_ACC = 12'h020;
	localparam logic [INSTR_WIDTH-1:0] M_MOVE_FILE = 12'hfc0;
	localparam logic [INSTR_WIDTH-1:0] V_MOVE_FILE = 12'h200;
	localparam logic [INSTR_WIDTH-1:0] M_LDLIT     = 12'hf00;
	localparam logic [INSTR_WIDTH-1:0] V_LDLIT     = 12'hc00;

	typedef enum logic [8:0] {
		CSE_OP_NONE  = 9'h001,
		CSE_OP_INC   = 9'h002,
		CSE_OP_INCSZ = 9'h004,
		CSE_OP_BRA   = 9'h008,
		CSE_OP_ORLIT = 9'h010,
		CSE_OP_ORF   = 9'h020,
		CSE_OP_STORE = 9'h040,
		CSE_OP_MOVE  = 9'h080,
		CSE_OP_LDLIT = 9'h100
	} cse_op_t;

	typedef enum logic [1:0] {
		CSE_ST_EXEC  = 2'h1,
		CSE_ST_FLUSH = 2'h2
	} cse_state_t;

endpackage

// [cse_decode.sv]
// opcode and field decoder for the instruction subset
`timescale 1ns/1ps
module cse_decode (
	// instruction word
	input  wire logic [cse_pkg::INSTR_WIDTH-1:0] instr,
	// decoded operation and fields
	output cse_pkg::cse_op_t                     op,
	output logic [cse_pkg::FADDR_WIDTH-1:0]      faddr,
	output logic                                 dest,
	output logic [cse_pkg::DATA_WIDTH-1:0]       lit,
	output logic [cse_pkg::TGT_WIDTH-1:0]        target
);

	function automatic logic hit(input logic [cse_pkg::INSTR_WIDTH-1:0] w,
		input logic [cse_pkg::INSTR_WIDTH-1:0] m, input logic [cse_pkg::INSTR_WIDTH-1:0] v);
		hit = ((w & m) == v);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// words outside this group fall through as no_operation
	always_comb
	begin
		if (hit(instr, cse_pkg::M_INC_FILE, cse_pkg::V_INC_FILE))
			op = cse_pkg::CSE_OP_INC;
		else if (hit(instr, cse_pkg::M_INC_SKIP, cse_pkg::V_INC_SKIP))
			op = cse_pkg::CSE_OP_INCSZ;
		else if (hit(instr, cse_pkg::M_BRANCH, cse_pkg::V_BRANCH))
			op = cse_pkg::CSE_OP_BRA;
		else if (hit(instr, cse_pkg::M_ORLIT, cse_pkg::V_ORLIT))
			op = cse_pkg::CSE_OP_ORLIT;
		else if (hit(instr, cse_pkg::M_ORFILE, cse_pkg::V_ORFILE))
			op = cse_pkg::CSE_OP_ORF;
		else if (hit(instr, cse_pkg::M_STORE_ACC, cse_pkg::V_STORE_ACC))
			op = cse_pkg::CSE_OP_STORE;
		else if (hit(instr, cse_pkg::M_MOVE_FILE, cse_pkg::V_MOVE_FILE))
			op = cse_pkg::CSE_OP_MOVE;
		else if (hit(instr, cse_pkg::M_LDLIT, cse_pkg::V_LDLIT))
			op = cse_pkg::CSE_OP_LDLIT;
		else
			op = cse_pkg::CSE_OP_NONE;
	end

	assign faddr  = instr[cse_pkg::FADDR_LSB +: cse_pkg::FADDR_WIDTH];
	assign dest   = instr[cse_pkg::DEST_BIT];
	assign lit    = instr[cse_pkg::LIT_LSB +: cse_pkg::DATA_WIDTH];
	assign target = instr[cse_pkg::TGT_LSB +: cse_pkg::TGT_WIDTH];

endmodule // cse_decode

// [cse_alu.sv]
// result and zero test for the arithmetic and move operations
`timescale 1ns/1ps
module cse_alu (
	// operation and operands
	input  wire cse_pkg::cse_op_t                 op,
	input  wire logic [cse_pkg::DATA_WIDTH-1:0]   acc,
	input  wire logic [cse_pkg::DATA_WIDTH-1:0]   fdata,
	input  wire logic [cse_pkg::DATA_WIDTH-1:0]   lit,
	// result
	output logic [cse_pkg::DATA_WIDTH-1:0]        result,
	output logic                                  zero
);

	always_comb
	begin
		unique case (op)
			cse_pkg::CSE_OP_INC, cse_pkg::CSE_OP_INCSZ:
				result = fdata + cse_pkg::ONE;
			cse_pkg::CSE_OP_ORLIT:
				result = acc | lit;
			cse_pkg::CSE_OP_ORF:
				result = acc | fdata;
			cse_pkg::CSE_OP_MOVE:
				result = fdata;
			cse_pkg::CSE_OP_LDLIT:
				result = lit;
			default:
				result = acc;
		endcase
	end

	assign zero = (result == cse_pkg::ZERO_VAL);

endmodule // cse_alu

// [cse_file_model.sv]
// data file model: 32 registers, combinational read with forwarding of the pending write
`timescale 1ns/1ps
module cse_file_model (
	// clock
	input  wire logic                            clk,
	// read side
	input  wire logic [cse_pkg::FADDR_WIDTH-1:0] raddr,
	output logic [cse_pkg::DATA_WIDTH-1:0]       rdata,
	// write side
	input  wire logic                            we,
	input  wire logic [cse_pkg::FADDR_WIDTH-1:0] waddr,
	input  wire logic [cse_pkg::DATA_WIDTH-1:0]  wdata
);
	logic [cse_pkg::DATA_WIDTH-1:0] mem [0:31];

	////////////////////////////////////////////////////////////////
	// a write issued last cycle lands at this edge, so it is forwarded
	// to the word read in the same cycle, or back to back ops see stale data
	assign rdata = (we && (waddr == raddr)) ? wdata : mem[raddr];

	// plain always: the bench preloads words through the hierarchy
	always @(posedge clk)
		if (we)
			mem[waddr] <= wdata;
endmodule // cse_file_model

// [cse_exec_test.sv]
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module cse_exec_test;
	// stimulus
	logic                             clk         = 1'b0;
	logic                             rst         = 1'b1;
	logic                             instr_valid = 1'b0;
	logic [cse_pkg::INSTR_WIDTH-1:0]  instr       = 12'h000;
	logic [cse_pkg::PAGE_WIDTH-1:0]   page_bits   = 2'h0;
	// observed
	logic [cse_pkg::DATA_WIDTH-1:0]   file_rdata;
	logic                             file_we_r;
	logic [cse_pkg::FADDR_WIDTH-1:0]  file_waddr_r;
	logic [cse_pkg::DATA_WIDTH-1:0]   file_wdata_r;
	logic [cse_pkg::DATA_WIDTH-1:0]   acc_r;
	logic                             zero_r;
	logic [cse_pkg::PC_WIDTH-1:0]     pc_r;
	logic                             discard_r;
	// bookkeeping
	int                               miscompares     = 0;
	int                               samples_checked = 0;
	logic [cse_pkg::PC_WIDTH-1:0]     exp_pc          = 11'h000;
	logic [cse_pkg::PAGE_WIDTH-1:0]   pg              = 2'h0;

	always #5 clk = ~clk;

	cse_exec u_cse_exec (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
		.file_rdata(file_rdata), .page_bits(page_bits), .file_we_r(file_we_r),
		.file_waddr_r(file_waddr_r), .file_wdata_r(file_wdata_r), .acc_r(acc_r),
		.zero_r(zero_r), .pc_r(pc_r), .discard_r(discard_r));

	cse_file_model u_cse_file_model (.clk(clk), .raddr(instr[4:0]), .rdata(file_rdata),
		.we(file_we_r), .waddr(file_waddr_r), .wdata(file_wdata_r));

	////////////////////////////////////////////////////////////////
	// one word, or two back to back; valid drops after so nothing is taken twice
	task automatic issue(input logic [11:0] w0, input logic [11:0] w1, input bit two);
		@(posedge clk);
		instr <= w0;
		instr_valid <= 1'b1;
		page_bits <= pg;
		@(posedge clk);
		if (two)
		begin
			instr <= w1;
			@(posedge clk);
		end
		instr_valid <= 1'b0;
		#1;
		exp_pc = exp_pc + (two ? 11'h002 : 11'h001);
	endtask

	task automatic chk(input logic [7:0] a, input logic z, input logic d, input logic we);
		`CHK(acc_r, a)
		`CHK(zero_r, z)
		`CHK(pc_r, exp_pc)
		`CHK(discard_r, d)
		`CHK(file_we_r, we)
	endtask

	task automatic chk_wr(input logic [4:0] f, input logic [7:0] v);
		`CHK(file_waddr_r, f)
		`CHK(file_wdata_r, v)
	endtask

	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// increment both destinations
	task automatic s_inc_file;
		u_cse_file_model.mem[3] = 8'hff;
		u_cse_file_model.mem[4] = 8'h7f;
		issue(12'h283, 12'h000, 1'b0);
		chk(8'h00, 1'b1, 1'b0, 1'b0);
		issue(12'h2a3, 12'h000, 1'b0);
		chk(8'h00, 1'b1, 1'b0, 1'b1);
		chk_wr(5'h03, 8'h00);
		issue(12'h284, 12'h000, 1'b0);
		chk(8'h80, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic s_skip;
		u_cse_file_model.mem[5] = 8'hff;
		u_cse_file_model.mem[6] = 8'h10;
		issue(12'h3e5, 12'h000, 1'b0);
		chk(8'h80, 1'b0, 1'b1, 1'b1);
		chk_wr(5'h05, 8'h00);
		issue(12'hc77, 12'h000, 1'b0);
		chk(8'h80, 1'b0, 1'b0, 1'b0);
		// no skip: the following word runs
		issue(12'h3c6, 12'hc77, 1'b1);
		chk(8'h77, 1'b0, 1'b0, 1'b0);
		`CHK(u_cse_file_model.mem[5], 8'h00)
	endtask

	task automatic s_branch;
		logic [8:0] k;
		for (int p = 0; p < 4; p++)
		begin
			k = (p == 3) ? 9'h1ff : 9'(p * 165);
			pg = 2'(p);
			issue({3'h5, k}, 12'h000, 1'b0);
			exp_pc = {pg, k};
			chk(8'h77, 1'b0, 1'b1, 1'b0);
			issue(12'hc11, 12'h000, 1'b0);
			chk(8'h77, 1'b0, 1'b0, 1'b0);
			issue({3'h5, k}, 12'hc11, 1'b1);
			exp_pc = {pg, k} + 11'h001;
			chk(8'h77, 1'b0, 1'b0, 1'b0);
		end
	endtask

	task automatic s_or;
		u_cse_file_model.mem[7] = 8'h40;
		u_cse_file_model.mem[8] = 8'h00;
		issue(12'hc00, 12'h000, 1'b0);
		chk(8'h00, 1'b0, 1'b0, 1'b0);
		issue(12'hd00, 12'h000, 1'b0);
		chk(8'h00, 1'b1, 1'b0, 1'b0);
		issue(12'hd81, 12'h000, 1'b0);
		chk(8'h81, 1'b0, 1'b0, 1'b0);
		issue(12'h107, 12'h000, 1'b0);
		chk(8'hc1, 1'b0, 1'b0, 1'b0);
		issue(12'hc00, 12'h000, 1'b0);
		issue(12'h128, 12'h000, 1'b0);
		chk(8'h00, 1'b1, 1'b0, 1'b1);
		chk_wr(5'h08, 8'h00);
	endtask

	task automatic s_move;
		u_cse_file_model.mem[10] = 8'h00;
		issue(12'hca5, 12'h000, 1'b0);
		chk(8'ha5, 1'b1, 1'b0, 1'b0);
		issue(12'h029, 12'h000, 1'b0);
		chk(8'ha5, 1'b1, 1'b0, 1'b1);
		chk_wr(5'h09, 8'ha5);
		issue(12'h209, 12'h000, 1'b0);
		chk(8'ha5, 1'b0, 1'b0, 1'b0);
		issue(12'h22a, 12'h000, 1'b0);
		chk(8'ha5, 1'b1, 1'b0, 1'b1);
		chk_wr(5'h0a, 8'h00);
	endtask

	task automatic s_idle;
		issue(12'h000, 12'h000, 1'b0);
		chk(8'ha5, 1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk(8'ha5, 1'b1, 1'b0, 1'b0);
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(8'h00, 1'b0, 1'b0, 1'b0);
		`CHK(file_waddr_r, 5'h00)
		s_inc_file();
		s_skip();
		s_branch();
		s_or();
		s_move();
		s_idle();
		stop_test();
	end
endmodule // cse_exec_test
